/* File: hdl/mid_pkg.sv */
// constants, modes and carriers of the instruction decoder
// assumes one core clock; no registers reached by software
`default_nettype none
package mid_pkg;
    localparam int unsigned MID_BYTE_W = 8;
    localparam int unsigned MID_LEN_W = 2;
    localparam int unsigned MID_CYC_W = 3;

    // instruction lengths in bytes
    localparam logic [1:0] MID_LEN_1 = 2'h1;
    localparam logic [1:0] MID_LEN_2 = 2'h2;
    localparam logic [1:0] MID_LEN_3 = 2'h3;

    // instruction cycle counts of this core
    localparam logic [2:0] MID_CYC_1 = 3'h1;
    localparam logic [2:0] MID_CYC_2 = 3'h2;
    localparam logic [2:0] MID_CYC_3 = 3'h3;
    localparam logic [2:0] MID_CYC_5 = 3'h5;

    // values after reset
    localparam logic [2:0] MID_STALL_RST = 3'h0;
    localparam logic MID_READY_RST = 1'b0;

    // operand field positions
    localparam int unsigned MID_ABS_PAGE_LSB = 5;
    localparam int unsigned MID_PTR_SEL_BIT = 0;
    localparam int unsigned MID_REG_IDX_LSB = 0;

    typedef enum logic [4:0] {
        MID_OP_NONE = 5'b00000,
        MID_OP_ADD = 5'b00001,
        MID_OP_SUM_CARRY = 5'b00010,
        MID_OP_SUB_BORROW = 5'b00011,
        MID_OP_STEP_UP = 5'b00100,
        MID_OP_STEP_DOWN = 5'b00101,
        MID_OP_PTR_STEP = 5'b00110,
        MID_OP_MUL = 5'b00111,
        MID_OP_DIV = 5'b01000,
        MID_OP_DEC_ADJ = 5'b01001,
        MID_OP_AND = 5'b01010,
        MID_OP_OR = 5'b01011,
        MID_OP_XOR = 5'b01100,
        MID_OP_CLEAR = 5'b01101,
        MID_OP_INVERT = 5'b01110,
        MID_OP_SWAP = 5'b01111,
        MID_OP_ROT_L = 5'b10000,
        MID_OP_ROT_LC = 5'b10001,
        MID_OP_ROT_R = 5'b10010,
        MID_OP_ROT_RC = 5'b10011
    } mid_op_e;

    typedef enum logic [3:0] {
        MID_SRC_NONE = 4'b0000,
        MID_SRC_ACC = 4'b0001,
        MID_SRC_WORK_REG = 4'b0010,
        MID_SRC_DIRECT = 4'b0011,
        MID_SRC_INDIRECT = 4'b0100,
        MID_SRC_IMM = 4'b0101,
        MID_SRC_ACC_TO_DIR = 4'b0110,
        MID_SRC_IMM_TO_DIR = 4'b0111,
        MID_SRC_PTR = 4'b1000,
        MID_SRC_AB = 4'b1001
    } mid_src_e;

    typedef enum logic [2:0] {
        MID_DST_NONE = 3'b000,
        MID_DST_ACC = 3'b001,
        MID_DST_WORK_REG = 3'b010,
        MID_DST_DIRECT = 3'b011,
        MID_DST_INDIRECT = 3'b100,
        MID_DST_PTR = 3'b101,
        MID_DST_AB = 3'b110
    } mid_dst_e;

    typedef struct packed {
        mid_op_e op;
        mid_src_e src;
        mid_dst_e dst;
        logic [1:0] len;
        logic [2:0] cyc;
        logic [2:0] reg_idx;
        logic wr_cy;
        logic wr_ac;
        logic wr_ov;
        logic use_carry;
        logic legal;
    } mid_ctl_s;

    typedef struct packed {
        logic [15:0] rel_disp;
        logic [10:0] abs_addr;
        logic [15:0] long_addr;
        logic ptr_sel;
    } mid_opnd_s;

    localparam mid_ctl_s MID_CTL_RST = '0;
    localparam mid_opnd_s MID_OPND_RST = '0;
endpackage
`default_nettype wire

/* File: hdl/mid_operand_fmt.sv */
// operand byte formatting: displacement, short and long addresses, pointer pick
// assumes the two bytes after the opcode are already fetched
`default_nettype none
module mid_operand_fmt (
    // instruction bytes
    input wire logic [7:0] opcode,
    input wire logic [7:0] arg1,
    input wire logic [7:0] arg2,
    // formatted operands
    output var mid_pkg::mid_opnd_s opnd
);
    logic [15:0] rel_ext;
    logic [10:0] abs_ext;
    logic [15:0] long_ext;
    logic ptr_bit;

    assign rel_ext = {{8{arg1[7]}}, arg1};
    assign abs_ext = {opcode[7:mid_pkg::MID_ABS_PAGE_LSB], arg1};
    assign long_ext = {arg1, arg2};
    // external moves pick their pointer elsewhere; bit only meaningful for indirect forms
    assign ptr_bit = opcode[mid_pkg::MID_PTR_SEL_BIT];

    // one driver for the whole carrier
    assign opnd = {rel_ext, abs_ext, long_ext, ptr_bit};
endmodule
`default_nettype wire

/* File: hdl/mid_decode.sv */
// opcode decoder and cycle table for the arithmetic and logical groups
// assumes fetch offers opcode plus two following bytes on the core clock
//
// Functional notes
// - every opcode in these groups behaves exactly as the standard eight-bit instruction set.
// - timing follows this core's own cycle counts, given per opcode.
// - add: register 28-2F, direct 25, indirect 26-27, immediate 24.
// - sum_with_carry_in: register 38-3F, direct 35, indirect 36-37, immediate 34.
// - subtract_with_borrow: register 98-9F, direct 95, indirect 96-97, immediate 94.
// - step up: acc 04, register 08-0F, direct 05, indirect 06-07.
// - step_down: acc 14, register 18-1F, direct 15, indirect 16-17.
// - data_pointer step A3 is one byte, three cycles.
// - bitwise_and_op forms 58-5F, 55, 56-57, 54, 52, 53.
// - bitwise_or_op forms 48-4F, 45, 46-47, 44, 42, 43.
// - bitwise_xor_op register 68-6F one cycle, direct 65 two.
// - bitwise_xor_op indirect 66-67, immediate 64, 62, 63 three bytes.
// - one-cycle acc ops: clear E4, invert F4, swap C4, rotates 23 33 03 13.
// - relative operand byte is a signed two's-complement displacement.
// - short destinations are 11-bit addresses, long ones 16-bit.
// - indirect operands use work register zero or one by low opcode bit.
`default_nettype none
module mid_decode (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // from fetch unit
    input wire logic op_valid,
    input wire logic [7:0] op_byte,
    input wire logic [7:0] op_arg1,
    input wire logic [7:0] op_arg2,
    output logic op_ready,
    // to sequencer and datapath
    output logic ctl_valid,
    output var mid_pkg::mid_ctl_s ctl,
    output var mid_pkg::mid_opnd_s opnd
);
    // length and cycles follow the operand form
    function automatic mid_pkg::mid_ctl_s mk(input mid_pkg::mid_op_e op, input mid_pkg::mid_src_e src,
                                             input logic [7:0] code);
        mid_pkg::mid_ctl_s c;
        c = mid_pkg::MID_CTL_RST;
        c.op = op;
        c.src = src;
        c.legal = 1'b1;
        c.reg_idx = code[2:0];
        c.dst = mid_pkg::MID_DST_ACC;
        case (src)
            mid_pkg::MID_SRC_DIRECT, mid_pkg::MID_SRC_IMM: begin
                c.len = mid_pkg::MID_LEN_2;
                c.cyc = mid_pkg::MID_CYC_2;
            end
            mid_pkg::MID_SRC_ACC_TO_DIR: begin
                c.len = mid_pkg::MID_LEN_2;
                c.cyc = mid_pkg::MID_CYC_2;
                c.dst = mid_pkg::MID_DST_DIRECT;
            end
            mid_pkg::MID_SRC_IMM_TO_DIR: begin
                c.len = mid_pkg::MID_LEN_3;
                c.cyc = mid_pkg::MID_CYC_3;
                c.dst = mid_pkg::MID_DST_DIRECT;
            end
            mid_pkg::MID_SRC_PTR: begin
                c.len = mid_pkg::MID_LEN_1;
                c.cyc = mid_pkg::MID_CYC_3;
                c.dst = mid_pkg::MID_DST_PTR;
            end
            mid_pkg::MID_SRC_AB: begin
                c.len = mid_pkg::MID_LEN_1;
                c.cyc = mid_pkg::MID_CYC_5;
                c.dst = mid_pkg::MID_DST_AB;
            end
            default: begin
                c.len = mid_pkg::MID_LEN_1;
                c.cyc = mid_pkg::MID_CYC_1;
            end
        endcase
        // step ops write back where the operand came from
        if (op == mid_pkg::MID_OP_STEP_UP || op == mid_pkg::MID_OP_STEP_DOWN) begin
            case (src)
                mid_pkg::MID_SRC_WORK_REG: c.dst = mid_pkg::MID_DST_WORK_REG;
                mid_pkg::MID_SRC_DIRECT: c.dst = mid_pkg::MID_DST_DIRECT;
                mid_pkg::MID_SRC_INDIRECT: c.dst = mid_pkg::MID_DST_INDIRECT;
                default: c.dst = mid_pkg::MID_DST_ACC;
            endcase
        end
        // flag effects as in the standard set
        case (op)
            mid_pkg::MID_OP_ADD: begin
                c.wr_cy = 1'b1;
                c.wr_ac = 1'b1;
                c.wr_ov = 1'b1;
            end
            mid_pkg::MID_OP_SUM_CARRY, mid_pkg::MID_OP_SUB_BORROW: begin
                c.wr_cy = 1'b1;
                c.wr_ac = 1'b1;
                c.wr_ov = 1'b1;
                c.use_carry = 1'b1;
            end
            mid_pkg::MID_OP_MUL, mid_pkg::MID_OP_DIV: begin
                c.wr_cy = 1'b1;
                c.wr_ov = 1'b1;
            end
            mid_pkg::MID_OP_DEC_ADJ: begin
                c.wr_cy = 1'b1;
                c.use_carry = 1'b1;
            end
            mid_pkg::MID_OP_ROT_LC, mid_pkg::MID_OP_ROT_RC: begin
                c.wr_cy = 1'b1;
                c.use_carry = 1'b1;
            end
            default: c.wr_cy = 1'b0;
        endcase
        return c;
    endfunction

    // full opcode table of the groups this block covers
    function automatic mid_pkg::mid_ctl_s lookup(input logic [7:0] b);
        mid_pkg::mid_ctl_s c;
        c = mid_pkg::MID_CTL_RST;
        casez (b)
            8'b0010_1???: c = mk(mid_pkg::MID_OP_ADD, mid_pkg::MID_SRC_WORK_REG, b);
            8'h25: c = mk(mid_pkg::MID_OP_ADD, mid_pkg::MID_SRC_DIRECT, b);
            8'b0010_011?: c = mk(mid_pkg::MID_OP_ADD, mid_pkg::MID_SRC_INDIRECT, b);
            8'h24: c = mk(mid_pkg::MID_OP_ADD, mid_pkg::MID_SRC_IMM, b);
            8'b0011_1???: c = mk(mid_pkg::MID_OP_SUM_CARRY, mid_pkg::MID_SRC_WORK_REG, b);
            8'h35: c = mk(mid_pkg::MID_OP_SUM_CARRY, mid_pkg::MID_SRC_DIRECT, b);
            8'b0011_011?: c = mk(mid_pkg::MID_OP_SUM_CARRY, mid_pkg::MID_SRC_INDIRECT, b);
            8'h34: c = mk(mid_pkg::MID_OP_SUM_CARRY, mid_pkg::MID_SRC_IMM, b);
            8'b1001_1???: c = mk(mid_pkg::MID_OP_SUB_BORROW, mid_pkg::MID_SRC_WORK_REG, b);
            8'h95: c = mk(mid_pkg::MID_OP_SUB_BORROW, mid_pkg::MID_SRC_DIRECT, b);
            8'b1001_011?: c = mk(mid_pkg::MID_OP_SUB_BORROW, mid_pkg::MID_SRC_INDIRECT, b);
            8'h94: c = mk(mid_pkg::MID_OP_SUB_BORROW, mid_pkg::MID_SRC_IMM, b);
            8'h04: c = mk(mid_pkg::MID_OP_STEP_UP, mid_pkg::MID_SRC_ACC, b);
            8'b0000_1???: c = mk(mid_pkg::MID_OP_STEP_UP, mid_pkg::MID_SRC_WORK_REG, b);
            8'h05: c = mk(mid_pkg::MID_OP_STEP_UP, mid_pkg::MID_SRC_DIRECT, b);
            8'b0000_011?: c = mk(mid_pkg::MID_OP_STEP_UP, mid_pkg::MID_SRC_INDIRECT, b);
            8'h14: c = mk(mid_pkg::MID_OP_STEP_DOWN, mid_pkg::MID_SRC_ACC, b);
            8'b0001_1???: c = mk(mid_pkg::MID_OP_STEP_DOWN, mid_pkg::MID_SRC_WORK_REG, b);
            8'h15: c = mk(mid_pkg::MID_OP_STEP_DOWN, mid_pkg::MID_SRC_DIRECT, b);
            8'b0001_011?: c = mk(mid_pkg::MID_OP_STEP_DOWN, mid_pkg::MID_SRC_INDIRECT, b);
            8'ha3: c = mk(mid_pkg::MID_OP_PTR_STEP, mid_pkg::MID_SRC_PTR, b);
            8'ha4: c = mk(mid_pkg::MID_OP_MUL, mid_pkg::MID_SRC_AB, b);
            8'h84: c = mk(mid_pkg::MID_OP_DIV, mid_pkg::MID_SRC_AB, b);
            8'hd4: c = mk(mid_pkg::MID_OP_DEC_ADJ, mid_pkg::MID_SRC_ACC, b);
            8'b0101_1???: c = mk(mid_pkg::MID_OP_AND, mid_pkg::MID_SRC_WORK_REG, b);
            8'h55: c = mk(mid_pkg::MID_OP_AND, mid_pkg::MID_SRC_DIRECT, b);
            8'b0101_011?: c = mk(mid_pkg::MID_OP_AND, mid_pkg::MID_SRC_INDIRECT, b);
            8'h54: c = mk(mid_pkg::MID_OP_AND, mid_pkg::MID_SRC_IMM, b);
            8'h52: c = mk(mid_pkg::MID_OP_AND, mid_pkg::MID_SRC_ACC_TO_DIR, b);
            8'h53: c = mk(mid_pkg::MID_OP_AND, mid_pkg::MID_SRC_IMM_TO_DIR, b);
            8'b0100_1???: c = mk(mid_pkg::MID_OP_OR, mid_pkg::MID_SRC_WORK_REG, b);
            8'h45: c = mk(mid_pkg::MID_OP_OR, mid_pkg::MID_SRC_DIRECT, b);
            8'b0100_011?: c = mk(mid_pkg::MID_OP_OR, mid_pkg::MID_SRC_INDIRECT, b);
            8'h44: c = mk(mid_pkg::MID_OP_OR, mid_pkg::MID_SRC_IMM, b);
            8'h42: c = mk(mid_pkg::MID_OP_OR, mid_pkg::MID_SRC_ACC_TO_DIR, b);
            8'h43: c = mk(mid_pkg::MID_OP_OR, mid_pkg::MID_SRC_IMM_TO_DIR, b);
            8'b0110_1???: c = mk(mid_pkg::MID_OP_XOR, mid_pkg::MID_SRC_WORK_REG, b);
            8'h65: c = mk(mid_pkg::MID_OP_XOR, mid_pkg::MID_SRC_DIRECT, b);
            8'b0110_011?: c = mk(mid_pkg::MID_OP_XOR, mid_pkg::MID_SRC_INDIRECT, b);
            8'h64: c = mk(mid_pkg::MID_OP_XOR, mid_pkg::MID_SRC_IMM, b);
            8'h62: c = mk(mid_pkg::MID_OP_XOR, mid_pkg::MID_SRC_ACC_TO_DIR, b);
            8'h63: c = mk(mid_pkg::MID_OP_XOR, mid_pkg::MID_SRC_IMM_TO_DIR, b);
            8'he4: c = mk(mid_pkg::MID_OP_CLEAR, mid_pkg::MID_SRC_ACC, b);
            8'hf4: c = mk(mid_pkg::MID_OP_INVERT, mid_pkg::MID_SRC_ACC, b);
            8'hc4: c = mk(mid_pkg::MID_OP_SWAP, mid_pkg::MID_SRC_ACC, b);
            8'h23: c = mk(mid_pkg::MID_OP_ROT_L, mid_pkg::MID_SRC_ACC, b);
            8'h33: c = mk(mid_pkg::MID_OP_ROT_LC, mid_pkg::MID_SRC_ACC, b);
            8'h03: c = mk(mid_pkg::MID_OP_ROT_R, mid_pkg::MID_SRC_ACC, b);
            8'h13: c = mk(mid_pkg::MID_OP_ROT_RC, mid_pkg::MID_SRC_ACC, b);
            // other groups belong to neighbouring decoders; flag and take one cycle
            default: begin
                c = mid_pkg::MID_CTL_RST;
                c.len = mid_pkg::MID_LEN_1;
                c.cyc = mid_pkg::MID_CYC_1;
            end
        endcase
        return c;
    endfunction

    mid_pkg::mid_ctl_s ctl_reg, ctl_next;
    mid_pkg::mid_opnd_s opnd_reg, opnd_next;
    logic ctl_valid_reg, ctl_valid_next;
    logic ready_reg, ready_next;
    logic [2:0] stall_reg, stall_next;
    mid_pkg::mid_ctl_s table_hit;
    mid_pkg::mid_opnd_s fmt_out;
    logic take;
    logic [2:0] stall_load;

    mid_operand_fmt u_fmt (
        .opcode(op_byte),
        .arg1(op_arg1),
        .arg2(op_arg2),
        .opnd(fmt_out)
    );

    assign table_hit = lookup(op_byte);
    assign take = op_valid & ready_reg;
    // sequencer is held off for the extra cycles of the instruction
    assign stall_load = table_hit.cyc - mid_pkg::MID_CYC_1;
    // all fields move together on the same edge
    assign ctl_next = take ? table_hit : ctl_reg;
    assign opnd_next = take ? fmt_out : opnd_reg;
    assign ctl_valid_next = take;
    assign stall_next = take ? stall_load : (stall_reg != 3'h0) ? stall_reg - 3'h1 : 3'h0;
    assign ready_next = take ? (stall_load == 3'h0) : (stall_reg <= 3'h1);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctl_reg <= mid_pkg::MID_CTL_RST;
            opnd_reg <= mid_pkg::MID_OPND_RST;
            ctl_valid_reg <= 1'b0;
            ready_reg <= mid_pkg::MID_READY_RST;
            stall_reg <= mid_pkg::MID_STALL_RST;
        end else begin
            ctl_reg <= ctl_next;
            opnd_reg <= opnd_next;
            ctl_valid_reg <= ctl_valid_next;
            ready_reg <= ready_next;
            stall_reg <= stall_next;
        end
    end

    assign op_ready = ready_reg;
    assign ctl_valid = ctl_valid_reg;
    assign ctl = ctl_reg;
    assign opnd = opnd_reg;
endmodule
`default_nettype wire

/* File: verification/mid_decode_assertions.sv */
// timing and operand checks on the decoder's ports
// assumes one core clock and the active-low async reset
`default_nettype none
module mid_decode_assertions (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // fetch side
    input wire logic op_valid,
    input wire logic [7:0] op_byte,
    input wire logic [7:0] op_arg1,
    input wire logic [7:0] op_arg2,
    input wire logic op_ready,
    // decoded side
    input wire logic ctl_valid,
    input wire mid_pkg::mid_ctl_s ctl,
    input wire mid_pkg::mid_opnd_s opnd
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    wire logic take = op_valid && op_ready;
    logic [23:0] took_reg;
    // copy of the taken bytes, so operand checks need no deep $past
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) took_reg <= 24'h000000;
        else if (take) took_reg <= {op_byte, op_arg1, op_arg2};
    end
    a_pulse_has_cause: assert property (ctl_valid |-> $past(take))
        else $error("decode pulse without a take");
    a_take_gives_pulse: assert property (take |=> ctl_valid)
        else $error("take without decode pulse");
    a_one_cycle_ready: assert property (ctl_valid && ctl.cyc == 3'h1 |-> op_ready)
        else $error("one cycle opcode stalled");
    a_three_cycle_stall: assert property (ctl_valid && ctl.cyc == 3'h3 |->
        !op_ready ##1 !op_ready ##1 op_ready)
        else $error("three cycle stall wrong");
    a_five_cycle_stall: assert property (ctl_valid && ctl.cyc == 3'h5 |-> !op_ready [*4] ##1 op_ready)
        else $error("five cycle stall wrong");
    a_ptr_step_len: assert property (ctl_valid && took_reg[23:16] == 8'ha3 |->
        ctl.len == 2'h1 && ctl.cyc == 3'h3)
        else $error("pointer step length or cycles wrong");
    a_imm_dir_len: assert property (ctl_valid && ctl.src == mid_pkg::MID_SRC_IMM_TO_DIR |->
        ctl.len == 2'h3)
        else $error("immediate to direct length wrong");
    a_rel_sign_ext: assert property (ctl_valid |-> opnd.rel_disp == {{8{took_reg[15]}}, took_reg[15:8]})
        else $error("displacement not sign extended");
    a_addr_forms: assert property (ctl_valid |-> opnd.abs_addr == {took_reg[23:21], took_reg[15:8]}
        && opnd.long_addr == took_reg[15:0])
        else $error("address operand wrong");
    a_ptr_pick: assert property (ctl_valid |-> opnd.ptr_sel == took_reg[16])
        else $error("pointer register pick wrong");
    a_ctl_holds: assert property (!ctl_valid |-> $stable(ctl) && $stable(opnd))
        else $error("controls changed without a take");
endmodule
`default_nettype wire

/* File: verification/mid_fetch_model.sv */
// fetch unit model: offers opcode plus two bytes, holds them until taken
// assumes the bench fills its queue through push
`default_nettype none
module mid_fetch_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // stall request from bench
    input wire logic slow,
    // to decoder
    input wire logic op_ready,
    output logic op_valid = 1'b0,
    output logic [7:0] op_byte = 8'h00,
    output logic [7:0] op_arg1 = 8'h00,
    output logic [7:0] op_arg2 = 8'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] q[$];
    task automatic push(input logic [7:0] c, input logic [7:0] a, input logic [7:0] b);
        q.push_back({c, a, b});
    endtask
    // idle lines flip every cycle so a stale byte never looks valid
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            q.delete();
            op_valid <= 1'b0;
        end else if (op_valid && !op_ready) begin
            op_valid <= 1'b1;
        end else if (q.size() > 0 && !slow) begin
            op_valid <= 1'b1;
            {op_byte, op_arg1, op_arg2} <= q.pop_front();
        end else begin
            op_valid <= 1'b0;
            {op_byte, op_arg1, op_arg2} <= ~{op_byte, op_arg1, op_arg2};
        end
    end
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// self-checking bench: every opcode, back-to-back runs, stalls, reset mid-run
// assumes the fetch model and the bound checker beside the decoder
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        mid_pkg::mid_op_e op;
        mid_pkg::mid_src_e src;
        logic [1:0] len;
        logic [2:0] cyc;
        logic carry;
        logic legal;
    } mid_exp_s;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic slow = 1'b0;
    logic op_valid, op_ready, ctl_valid, pend, want_rdy;
    logic [7:0] op_byte, op_arg1, op_arg2;
    logic [23:0] took;
    mid_pkg::mid_ctl_s ctl;
    mid_pkg::mid_opnd_s opnd;
    mid_exp_s e, got;
    int seed = 14357;
    int miscompares = 0;
    int tests_run = 0;
    int gap = 0;
    logic [7:0] corner [8] = '{8'h28, 8'h29, 8'h53, 8'h04, 8'ha3, 8'h28, 8'ha4, 8'he4};
    always #10 clk_sys = ~clk_sys;
    mid_decode dut (.clk_sys(clk_sys), .rstn(rstn), .op_valid(op_valid), .op_byte(op_byte), .op_arg1(op_arg1),
        .op_arg2(op_arg2), .op_ready(op_ready), .ctl_valid(ctl_valid), .ctl(ctl), .opnd(opnd));
    mid_fetch_model fetch (.clk_sys(clk_sys), .rstn(rstn), .slow(slow), .op_ready(op_ready), .op_valid(op_valid),
        .op_byte(op_byte), .op_arg1(op_arg1), .op_arg2(op_arg2));
    function automatic mid_exp_s expect_of(input logic [7:0] c);
        mid_exp_s x;
        logic lgc;
        x = '{mid_pkg::MID_OP_NONE, mid_pkg::MID_SRC_NONE, 2'h1, 3'h1, 1'b0, 1'b0};
        lgc = c[7:4] inside {4'h4, 4'h5, 4'h6};
        case (c[7:4])
            4'h0: x.op = mid_pkg::MID_OP_STEP_UP;
            4'h1: x.op = mid_pkg::MID_OP_STEP_DOWN;
            4'h2: x.op = mid_pkg::MID_OP_ADD;
            4'h3: x.op = mid_pkg::MID_OP_SUM_CARRY;
            4'h9: x.op = mid_pkg::MID_OP_SUB_BORROW;
            4'h5: x.op = mid_pkg::MID_OP_AND;
            4'h4: x.op = mid_pkg::MID_OP_OR;
            4'h6: x.op = mid_pkg::MID_OP_XOR;
            default: x.op = mid_pkg::MID_OP_NONE;
        endcase
        if (c[3]) x.src = mid_pkg::MID_SRC_WORK_REG;
        else if (c[3:1] == 3'h3) x.src = mid_pkg::MID_SRC_INDIRECT;
        else if (c[3:0] == 4'h5) x.src = mid_pkg::MID_SRC_DIRECT;
        else if (c[3:0] == 4'h4) x.src = (c[7:5] == 3'h0) ? mid_pkg::MID_SRC_ACC : mid_pkg::MID_SRC_IMM;
        else if (c[3:0] == 4'h2 && lgc) x.src = mid_pkg::MID_SRC_ACC_TO_DIR;
        else if (c[3:0] == 4'h3 && lgc) x.src = mid_pkg::MID_SRC_IMM_TO_DIR;
        else x.op = mid_pkg::MID_OP_NONE;
        case (c)
            8'h03: x.op = mid_pkg::MID_OP_ROT_R;
            8'h13: x.op = mid_pkg::MID_OP_ROT_RC;
            8'h23: x.op = mid_pkg::MID_OP_ROT_L;
            8'h33: x.op = mid_pkg::MID_OP_ROT_LC;
            8'he4: x.op = mid_pkg::MID_OP_CLEAR;
            8'hf4: x.op = mid_pkg::MID_OP_INVERT;
            8'hc4: x.op = mid_pkg::MID_OP_SWAP;
            8'hd4: x.op = mid_pkg::MID_OP_DEC_ADJ;
            8'ha3: x.op = mid_pkg::MID_OP_PTR_STEP;
            8'ha4: x.op = mid_pkg::MID_OP_MUL;
            8'h84: x.op = mid_pkg::MID_OP_DIV;
            default: ;
        endcase
        if (c inside {8'h03, 8'h13, 8'h23, 8'h33, 8'he4, 8'hf4, 8'hc4, 8'hd4}) x.src = mid_pkg::MID_SRC_ACC;
        if (c == 8'ha3) x.src = mid_pkg::MID_SRC_PTR;
        if (c inside {8'ha4, 8'h84}) x.src = mid_pkg::MID_SRC_AB;
        x.legal = x.op != mid_pkg::MID_OP_NONE;
        if (!x.legal) x.src = mid_pkg::MID_SRC_NONE;
        if (x.src inside {mid_pkg::MID_SRC_DIRECT, mid_pkg::MID_SRC_IMM, mid_pkg::MID_SRC_ACC_TO_DIR}) x.len = 2'h2;
        if (x.src == mid_pkg::MID_SRC_IMM_TO_DIR) x.len = 2'h3;
        x.cyc = {1'b0, x.len};
        if (c == 8'ha3) x.cyc = 3'h3;
        if (x.src == mid_pkg::MID_SRC_AB) x.cyc = 3'h5;
        x.carry = x.op inside {mid_pkg::MID_OP_SUM_CARRY, mid_pkg::MID_OP_SUB_BORROW, mid_pkg::MID_OP_ROT_LC,
            mid_pkg::MID_OP_ROT_RC, mid_pkg::MID_OP_DEC_ADJ};
        return x;
    endfunction
    // destination and flag writes of the standard set
    function automatic logic [5:0] side_of(input mid_exp_s x);
        logic step;
        logic [2:0] d;
        logic [2:0] f;
        step = x.op inside {mid_pkg::MID_OP_STEP_UP, mid_pkg::MID_OP_STEP_DOWN};
        d = x.legal ? mid_pkg::MID_DST_ACC : mid_pkg::MID_DST_NONE;
        if (x.src inside {mid_pkg::MID_SRC_ACC_TO_DIR, mid_pkg::MID_SRC_IMM_TO_DIR}) d = mid_pkg::MID_DST_DIRECT;
        if (x.src == mid_pkg::MID_SRC_PTR) d = mid_pkg::MID_DST_PTR;
        if (x.src == mid_pkg::MID_SRC_AB) d = mid_pkg::MID_DST_AB;
        if (step && x.src == mid_pkg::MID_SRC_WORK_REG) d = mid_pkg::MID_DST_WORK_REG;
        if (step && x.src == mid_pkg::MID_SRC_DIRECT) d = mid_pkg::MID_DST_DIRECT;
        if (step && x.src == mid_pkg::MID_SRC_INDIRECT) d = mid_pkg::MID_DST_INDIRECT;
        f[2] = x.carry | (x.op inside {mid_pkg::MID_OP_ADD, mid_pkg::MID_OP_MUL, mid_pkg::MID_OP_DIV});
        f[1] = x.op inside {mid_pkg::MID_OP_ADD, mid_pkg::MID_OP_SUM_CARRY, mid_pkg::MID_OP_SUB_BORROW};
        f[0] = f[1] | (x.op inside {mid_pkg::MID_OP_MUL, mid_pkg::MID_OP_DIV});
        return {d, f};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            miscompares++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic stop_test;
        if (miscompares == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // scoreboard on sampled values; expectations come from expect_of and side_of, not the decoder's table
    always @(posedge clk_sys) begin
        if (!rstn) begin
            pend = 1'b0;
            gap = 0;
            want_rdy = 1'b0;
        end else begin
            check(ctl_valid, pend);
            if (pend) begin
                got = {ctl.op, ctl.src, ctl.len, ctl.cyc, ctl.use_carry, ctl.legal};
                check(got[15:7], e[15:7]);
                check(got, e);
                check({ctl.dst, ctl.wr_cy, ctl.wr_ac, ctl.wr_ov}, side_of(e));
                check(opnd.rel_disp, {{8{took[15]}}, took[15:8]});
                check({opnd.abs_addr, opnd.long_addr}, {took[23:21], took[15:8], took[15:0]});
                check({ctl.reg_idx, opnd.ptr_sel}, {e.legal ? took[18:16] : 3'h0, took[16]});
            end
            if (gap > 0) begin
                check(op_ready, 1'b0);
                gap--;
            end else if (want_rdy) begin
                check(op_ready, 1'b1);
                want_rdy = 1'b0;
            end
            pend = op_valid && op_ready;
            if (pend) begin
                took = {op_byte, op_arg1, op_arg2};
                e = expect_of(op_byte);
                gap = int'(e.cyc) - 1;
                want_rdy = 1'b1;
            end
        end
    end
    task automatic drain(input logic stall);
        int n;
        int r;
        n = 0;
        while (fetch.q.size() > 0 || op_valid) begin
            @(posedge clk_sys);
            r = $random(seed);
            slow <= stall & r[0];
            n++;
            if (n > 4000) begin
                miscompares++;
                stop_test();
            end
        end
        repeat (8) @(posedge clk_sys);
        slow <= 1'b0;
    endtask
    initial begin
        int r;
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        // the model still flushes its queue on this edge
        @(posedge clk_sys);
        // back-to-back one-cycle codes around long stalls, sign boundary args
        foreach (corner[i]) fetch.push(corner[i], i[0] ? 8'h7f : 8'h80, 8'hff);
        drain(1'b0);
        for (int i = 0; i < 256; i++) begin
            r = $random(seed);
            fetch.push(i[7:0], r[7:0], r[15:8]);
        end
        drain(1'b1);
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 24; i++) begin
                r = $random(seed);
                fetch.push(r[7:0], r[15:8], r[23:16]);
            end
            repeat (7) @(posedge clk_sys);
            rstn <= 1'b0;
            @(negedge clk_sys);
            check({op_ready, ctl_valid, ctl}, 32'h0);
            check({opnd.rel_disp, opnd.long_addr}, 32'h0);
            repeat (3) @(posedge clk_sys);
            rstn <= 1'b1;
            @(posedge clk_sys);
        end
        for (int i = 0; i < 32; i++) begin
            r = $random(seed);
            fetch.push(r[7:0], r[15:8], r[23:16]);
        end
        drain(1'b1);
        stop_test();
    end
endmodule
bind mid_decode mid_decode_assertions u_chk (.clk_sys(clk_sys), .rstn(rstn), .op_valid(op_valid), .op_byte(op_byte),
    .op_arg1(op_arg1), .op_arg2(op_arg2), .op_ready(op_ready), .ctl_valid(ctl_valid), .ctl(ctl), .opnd(opnd));
`default_nettype wire
